// ===== common/read_cfg_consts.vh
// Offsets, field positions, reset values and timing counts for the
// read latency and execute-in-place configuration block.
// Assumes inclusion by bare name from the design files.
`ifndef READ_CFG_CONSTS_VH
`define READ_CFG_CONSTS_VH

// Register byte offsets on the Wishbone slave
`define OFS_READ_CONFIG      4'h0
`define OFS_ENHANCED_SETUP   4'h4
`define OFS_NONVOL_SETUP     4'h8
`define OFS_STATUS           4'hC

// Read config fields
`define DUMMY_MSB            7
`define DUMMY_LSB            4
`define XIP_BIT              3
`define READ_CONFIG_RESET    8'hF8
`define READ_CONFIG_WMASK    8'hF8

// Enhanced setup fields
`define QUAD_BIT             7
`define DUAL_BIT             6
`define ENH_RSVD_BIT         5
`define ENH_SETUP_RESET      8'hDF
`define ENH_SETUP_WMASK      8'hDF

// Dummy count codes
`define DUMMY_ZERO           4'h0
`define DUMMY_MAX            4'hF

// Protocol codes
`define PROTO_EXTENDED       2'h0
`define PROTO_TWO_LINE       2'h1
`define PROTO_FOUR_LINE      2'h2

// Status register bits
`define STS_PROTO_LSB        0
`define STS_XIP_BIT          2
`define STS_DUMMY_LSB        4

`endif

// ===== hdl/pin_sync.v
// Two-flop synchroniser for a bus of external levels.
// Assumes inputs asynchronous to core_clk.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             core_clk,
  input  wire             reset_n,
  input  wire             clk_en,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // Two stages; the first is read by the second only
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule
`default_nettype wire

// ===== hdl/dummy_counter.v
// Counts dummy link clocks after a fast read instruction.
// Assumes a one-cycle start pulse and a one-cycle link edge pulse.
`timescale 1ns/100ps
`default_nettype none
`include "read_cfg_consts.vh"
module dummy_counter (
  input  wire       core_clk,
  input  wire       reset_n,
  input  wire       clk_en,
  input  wire       start,
  input  wire       abort,
  input  wire       link_edge,
  input  wire [3:0] load_count,
  output wire       busy,
  output wire       first_edge,
  output reg        done_ff
);
  reg [3:0] left_ff;
  reg       first_ff;
  reg [3:0] nxt_left;

  assign busy       = (left_ff != 4'h0);
  assign first_edge = busy && first_ff && link_edge;

  // Next count
  always @* begin
    nxt_left = left_ff;
    if (abort)
      nxt_left = 4'h0;
    else if (start)
      nxt_left = load_count;
    else if (busy && link_edge)
      nxt_left = left_ff - 4'h1;
  end

  // Count state and done pulse
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      left_ff  <= 4'h0;
      first_ff <= 1'b0;
      done_ff  <= 1'b0;
    end else if (clk_en) begin
      left_ff  <= nxt_left;
      done_ff  <= !abort && busy && link_edge && (left_ff == 4'h1);
      if (start)
        first_ff <= 1'b1;
      else if (link_edge || abort)
        first_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/read_latency_cfg.v
// Volatile read latency, execute-in-place and protocol configuration.
// Assumes a classic Wishbone master on core_clk and link pins from
// outside the domain, sampled by two flip-flops.
`timescale 1ns/100ps
`default_nettype none
`include "read_cfg_consts.vh"
module read_latency_cfg #(
  parameter BASIC_XIP = 1'b0
) (
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        clk_en,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output wire        wb_err_o,
  // Link pins
  input  wire        link_clk,
  input  wire        link_select_n,
  input  wire        serial_data_line_zero,
  // Instruction decoder side
  input  wire        fast_read_start,
  input  wire [7:0]  nonvolatile_setup,
  // Results
  output reg  [3:0]  dummy_cycles,
  output reg         execute_in_place_armed,
  output reg         xip_confirm,
  output reg         xip_sample_valid,
  output reg  [1:0]  protocol_mode,
  output wire        dummy_busy,
  output reg         dummy_done
);

  // ------------------------------------------------------------
  // Decoding functions
  // ------------------------------------------------------------

  // Effective dummy count: code zero acts as fifteen
  function [3:0] eff_dummy;
    input [3:0] code;
    begin
      eff_dummy = (code == `DUMMY_ZERO) ? `DUMMY_MAX : code;
    end
  endfunction

  // Protocol from enhanced setup; four-line wins over two-line
  function [1:0] proto_of;
    input [7:0] setup;
    begin
      if (!setup[`QUAD_BIT])
        proto_of = `PROTO_FOUR_LINE;
      else if (!setup[`DUAL_BIT])
        proto_of = `PROTO_TWO_LINE;
      else
        proto_of = `PROTO_EXTENDED;
    end
  endfunction

  // ------------------------------------------------------------
  // Registers and bus
  // ------------------------------------------------------------

  reg  [7:0] read_config_ff;
  reg  [7:0] enh_setup_ff;
  reg        loaded_ff;
  reg        ack_ff;
  wire       bus_req;
  wire       bus_wr;
  wire       mapped;
  wire       dummy_first;
  wire       dummy_done_w;
  wire [2:0] link_sync;
  reg        link_clk_d_ff;
  wire       link_rise;
  wire       link_active;

  assign bus_req  = wb_cyc_i && wb_stb_i && !ack_ff;
  assign mapped   = (wb_adr_i == `OFS_READ_CONFIG) ||
                    (wb_adr_i == `OFS_ENHANCED_SETUP) ||
                    (wb_adr_i == `OFS_NONVOL_SETUP) ||
                    (wb_adr_i == `OFS_STATUS);
  assign bus_wr   = bus_req && wb_we_i && wb_sel_i[0];
  assign wb_err_o = 1'b0;

  // Config registers; power-on copy of nonvolatile setup once
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      read_config_ff <= `READ_CONFIG_RESET;
      enh_setup_ff   <= `ENH_SETUP_RESET;
      loaded_ff      <= 1'b0;
    end else if (clk_en) begin
      if (!loaded_ff) begin
        loaded_ff    <= 1'b1;
        enh_setup_ff <= nonvolatile_setup & `ENH_SETUP_WMASK;
      end else if (bus_wr && wb_adr_i == `OFS_ENHANCED_SETUP) begin
        enh_setup_ff <= wb_dat_i[7:0] & `ENH_SETUP_WMASK;
      end
      if (bus_wr && wb_adr_i == `OFS_READ_CONFIG)
        read_config_ff <= wb_dat_i[7:0] & `READ_CONFIG_WMASK;
    end
  end

  // Ack one cycle after the request, for every address
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff   <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en) begin
      ack_ff   <= bus_req;
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0000_0000;
      if (bus_req && !wb_we_i && mapped) begin
        case (wb_adr_i)
          `OFS_READ_CONFIG:
            wb_dat_o <= {24'h00_0000, read_config_ff};
          `OFS_ENHANCED_SETUP:
            wb_dat_o <= {24'h00_0000, enh_setup_ff};
          `OFS_NONVOL_SETUP:
            wb_dat_o <= {24'h00_0000, nonvolatile_setup};
          default:
            wb_dat_o <= {24'h00_0000, dummy_cycles, 1'b0,
                         execute_in_place_armed, protocol_mode};
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Link sampling
  // ------------------------------------------------------------

  pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    // Select goes in inverted, so the reset value means deselected
    .async_in ({serial_data_line_zero, ~link_select_n, link_clk}),
    .sync_out (link_sync)
  );

  // Rising edge of synchronised link clock
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      link_clk_d_ff <= 1'b0;
    else if (clk_en)
      link_clk_d_ff <= link_sync[0];
  end

  assign link_active = link_sync[1];
  assign link_rise   = link_sync[0] && !link_clk_d_ff && link_active;

  // ------------------------------------------------------------
  // Dummy clock phase
  // ------------------------------------------------------------

  dummy_counter u_dummy (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .clk_en     (clk_en),
    .start      (fast_read_start && link_active),
    .abort      (!link_active),
    .link_edge  (link_rise),
    .load_count (dummy_cycles),
    .busy       (dummy_busy),
    .first_edge (dummy_first),
    .done_ff    (dummy_done_w)
  );

  // Decoded outputs and first-dummy capture
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dummy_cycles           <= `DUMMY_MAX;
      execute_in_place_armed <= 1'b0;
      protocol_mode          <= `PROTO_EXTENDED;
      xip_confirm            <= 1'b0;
      xip_sample_valid       <= 1'b0;
      dummy_done             <= 1'b0;
    end else if (clk_en) begin
      dummy_cycles  <= eff_dummy(read_config_ff[`DUMMY_MSB:`DUMMY_LSB]);
      protocol_mode <= proto_of(enh_setup_ff);
      execute_in_place_armed <= BASIC_XIP ||
                                !read_config_ff[`XIP_BIT];
      dummy_done       <= dummy_done_w;
      xip_sample_valid <= dummy_first && execute_in_place_armed;
      if (dummy_first && execute_in_place_armed)
        xip_confirm <= link_sync[2];
    end
  end

endmodule
`default_nettype wire

// ===== bench/link_host.sv
// Host side of the link: select, data line zero and framed link clock.
// Assumes the bench calls its tasks; the link clock idles low.
`timescale 1ns/100ps
`default_nettype none
module link_host (
  output logic link_clk,
  output logic link_select_n,
  output logic serial_data_line_zero
);
  initial begin
    link_clk = 1'b0;
    link_select_n = 1'b1;
    serial_data_line_zero = 1'b0;
  end
  // Idle data line keeps moving so no stale level is trusted
  always #150 if (link_select_n)
    serial_data_line_zero = ~serial_data_line_zero;
  // Select the device and hold a chosen level on data line zero
  task automatic open_frame(input logic lvl);
    link_select_n = 1'b0;
    serial_data_line_zero = lvl;
  endtask
  // Slow fixed rate suits every dummy count
  task automatic pulses(input int n);
    repeat (n) begin
      #200 link_clk = 1'b1;
      #200 link_clk = 1'b0;
    end
  endtask
  task automatic close_frame;
    #200 link_select_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== bench/read_latency_cfg_chk.sv
// Checker on the ports of the read latency configuration block.
// Assumes single core_clk domain and classic Wishbone requests.
`timescale 1ns/100ps
`default_nettype none
module read_latency_cfg_chk #(
  parameter logic BASIC_XIP = 1'b0
) (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [3:0]  dummy_cycles,
  input wire logic        execute_in_place_armed,
  input wire logic        xip_sample_valid,
  input wire logic [1:0]  protocol_mode,
  input wire logic        dummy_busy,
  input wire logic        dummy_done
);
  logic [3:0] eff_w;
  logic [1:0] mode_w;
  logic       arm_w;
  // Values a write should leave behind
  assign eff_w = (wb_dat_i[7:4] == 4'h0) ? 4'hF : wb_dat_i[7:4];
  assign mode_w = !wb_dat_i[7] ? 2'h2 : (!wb_dat_i[6] ? 2'h1 : 2'h0);
  assign arm_w = BASIC_XIP | !wb_dat_i[3];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_cfg_wr;
    s_take and (wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h0);
  endsequence
  sequence s_enh_wr;
    s_take and (wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h4);
  endsequence
  property p_ack;
    s_take |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  property p_dummy_wr;
    s_cfg_wr |-> ##2 (dummy_cycles == $past(eff_w, 2));
  endproperty
  property p_xip_wr;
    s_cfg_wr |-> ##2 (execute_in_place_armed == $past(arm_w, 2));
  endproperty
  property p_proto_wr;
    s_enh_wr |-> ##2 (protocol_mode == $past(mode_w, 2));
  endproperty
  property p_no_zero;
    dummy_cycles != 4'h0;
  endproperty
  property p_rsvd;
    wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |-> wb_dat_o[2:0] == 3'h0;
  endproperty
  property p_sample;
    xip_sample_valid |-> execute_in_place_armed;
  endproperty
  property p_done;
    dummy_done |=> !dummy_done;
  endproperty
  property p_proto_ok;
    protocol_mode != 2'h3;
  endproperty
  property p_busy;
    dummy_done |-> $past(dummy_busy, 2) && !dummy_busy;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle");
  a_dummy_wr: assert property (p_dummy_wr)
    else $error("dummy count not updated");
  a_xip_wr: assert property (p_xip_wr)
    else $error("xip arming wrong");
  a_proto_wr: assert property (p_proto_wr)
    else $error("protocol not updated");
  a_no_zero: assert property (p_no_zero)
    else $error("dummy count zero");
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits set");
  a_sample: assert property (p_sample)
    else $error("sample while unarmed");
  a_done: assert property (p_done)
    else $error("done too long");
  a_proto_ok: assert property (p_proto_ok)
    else $error("bad protocol code");
  a_busy: assert property (p_busy)
    else $error("busy not ended at done");
endmodule
bind read_latency_cfg read_latency_cfg_chk #(.BASIC_XIP(BASIC_XIP)) u_chk (
  .core_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dummy_cycles,
  .execute_in_place_armed, .xip_sample_valid, .protocol_mode,
  .dummy_busy, .dummy_done);
`default_nettype wire

// ===== bench/tb.sv
// Bench: Wishbone register traffic and dummy frames, checked by queues.
// Assumes link_host drives the link pins and the checker is bound.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic        frs = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'hF;
  logic [3:0]  msk = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic [31:0] d;
  logic [7:0]  nv = 8'h0;
  logic [3:0]  code;
  logic [3:0]  eff;
  logic        xb;
  logic [31:0] rd_q[$];
  logic [31:0] cnt_q[$];
  logic [31:0] xip_q[$];
  wire  [31:0] rdat;
  wire         ack, lclk, lsel_n, d0, done, valid, conf;
  int          num_errors = 0;
  int          comparisons = 0;
  int          seed = 42;
  int          rises = 0;
  initial forever #25 core_clk = ~core_clk;
  always @(posedge lclk) rises <= rises + 1;
  read_latency_cfg u_dut (
    .core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(), .link_clk(lclk), .link_select_n(lsel_n),
    .serial_data_line_zero(d0), .fast_read_start(frs),
    .nonvolatile_setup(nv), .dummy_cycles(), .execute_in_place_armed(),
    .xip_confirm(conf), .xip_sample_valid(valid), .protocol_mode(),
    .dummy_busy(), .dummy_done(done));
  link_host u_host (.link_clk(lclk), .link_select_n(lsel_n),
    .serial_data_line_zero(d0));
  function automatic logic [1:0] pm(input logic [7:0] x);
    return !x[7] ? 2'h2 : (!x[6] ? 2'h1 : 2'h0);
  endfunction
  task automatic check(input string what, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic compare_read(input logic [31:0] e, g);
    check("read", e, g);
  endtask
  task automatic compare_edges(input logic [31:0] e, g);
    check("edges", e, g);
  endtask
  task automatic compare_xip(input logic [31:0] e, g);
    check("xip", e, g);
  endtask
  // Results taken off the queues as they appear
  always @(posedge core_clk) begin
    if (ack && !we) compare_read(rd_q.pop_front(), rdat);
    if (done) compare_edges(cnt_q.pop_front(), rises);
    if (valid) compare_xip(xip_q.pop_front(), conf);
  end
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] dt, e);
    if (!w) rd_q.push_back(e);
    @(posedge core_clk);
    cyc <= 1'b1;
    we <= w;
    sel <= msk;
    adr <= a;
    wdat <= dt;
    do @(posedge core_clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic frame(input logic [3:0] n, input logic lvl, arm);
    u_host.open_frame(lvl);
    repeat (4) @(posedge core_clk);
    frs <= 1'b1;
    cnt_q.push_back(rises + n);
    if (arm) xip_q.push_back({31'h0, lvl});
    @(posedge core_clk);
    frs <= 1'b0;
    u_host.pulses(n);
    repeat (10) @(posedge core_clk);
    u_host.close_frame;
  endtask
  task automatic test_done;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    @(posedge core_clk);
    nv <= $random(seed);
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    wb(0, 4'h0, 0, 32'hF8);
    wb(0, 4'h4, 0, {24'h0, nv & 8'hDF});
    wb(0, 4'hC, 0, {24'h0, 6'h3C, pm(nv)});
    for (int i = 0; i < 5; i++) begin
      code = (i == 0) ? 4'h0 : (i == 1) ? 4'h1 :
             (i == 2) ? 4'hF : $random(seed);
      eff = (code == 4'h0) ? 4'hF : code;
      xb = i[0];
      d = $random(seed);
      d[7:3] = {code, xb};
      wb(1, 4'h0, d, 0);
      wb(0, 4'h0, 0, {24'h0, code, xb, 3'h0});
      d = $random(seed);
      wb(1, 4'h4, d, 0);
      wb(0, 4'hC, 0, {24'h0, eff, 1'b0, ~xb, pm(d[7:0])});
      frame(eff, d[0], ~xb);
    end
    wb(0, 4'h6, 0, 0);
    wb(1, 4'h8, 32'h0, 0);
    wb(0, 4'h8, 0, {24'h0, nv});
    // Write without byte lane zero must leave the register alone
    msk = 4'hE;
    wb(1, 4'h0, 32'h07, 0);
    msk = 4'hF;
    wb(0, 4'h0, 0, {24'h0, code, xb, 3'h0});
    test_done;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    num_errors++;
    test_done;
  end
endmodule
`default_nettype wire
